//--- spisd_baud_gen.sv
`timescale 1ns/1ps
`default_nettype none
module spisd_baud_gen
	import spisd_pkg::*;
(
	// Clock and reset.
	input  wire logic       clk,
	input  wire logic       rst_b,
	// Control.
	input  wire logic       run,
	input  wire logic [1:0] sel,
	// One pulse at each half period of the serial clock.
	output logic            half_tick
);

	logic [7:0] cnt_reg;   // Bus clocks since the last half tick.
	logic [7:0] div_val;   // Full serial period in bus clocks.
	logic [7:0] half_cnt;  // Bus clocks per half serial period.

	assign div_val  = spisd_divisor(sel);
	assign half_cnt = {1'b0, div_val[7:1]};

	// ----------------------------------------------------------------
	// Divider
	// ----------------------------------------------------------------
	// bus clock divided.
	// Two half ticks make one serial period of the selected divisor.
	always_ff @(posedge clk) begin
		if (!rst_b || !run) begin
			cnt_reg   <= 8'h00;
			half_tick <= 1'b0;
		end else if (cnt_reg == half_cnt - 8'h01) begin
			cnt_reg   <= 8'h00;
			half_tick <= 1'b1;
		end else begin
			cnt_reg   <= cnt_reg + 8'h01;
			half_tick <= 1'b0;
		end
	end

endmodule
`default_nettype wire

//--- spisd_chk.sv
`timescale 1ns/1ps
`default_nettype none
module spisd_chk
	import spisd_pkg::*;
(
	// Clock, reset and watched ports.
	input wire logic           clk, rst_b, select_claimed,
	input wire logic           s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
	input wire logic           s_axi_bvalid, s_axi_arvalid, s_axi_arready,
	input wire logic           s_axi_rvalid, s_axi_rready,
	input wire spisd_pin_in_t  pin_in,
	input wire spisd_pin_out_t pin_out
);
	// Counts the high phase of the master clock; the low phase is not used because
	// the first low phase of a byte may be longer than half a period.
	logic [7:0] hi_cnt;
	always_ff @(posedge clk) begin
		if (!rst_b || !pin_out.sck_o)
			hi_cnt <= 8'h00;
		else
			hi_cnt <= hi_cnt + 8'h01;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// The write answer comes one idle cycle after both halves are taken.
	sequence resp_s;
		!s_axi_bvalid ##1 s_axi_bvalid;
	endsequence
	baud_half_a: assert property ($fell(pin_out.sck_o) && pin_out.sck_oe
		|-> hi_cnt inside {8'h01, 8'h04, 8'h10, 8'h40}) else $error("bad half period");
	mosi_hold_a: assert property (pin_out.sck_oe && pin_out.sck_o
		|-> $stable(pin_out.mosi_o)) else $error("data moved while clock high");
	miso_float_a: assert property (pin_in.ss_n [*4]
		|-> !pin_out.miso_oe) else $error("deselected slave drives");
	slave_claim_a: assert property (pin_out.miso_oe |-> select_claimed)
		else $error("select not claimed");
	role_excl_a: assert property (pin_out.sck_oe |-> !pin_out.miso_oe)
		else $error("both roles drive");
	read_ans_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("late read answer");
	write_ans_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |=> resp_s) else $error("bad write answer");
	read_once_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read answered twice");
endmodule
bind spisd_top spisd_chk u_chk (.clk, .rst_b, .select_claimed, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rvalid, .s_axi_rready, .pin_in, .pin_out);
`default_nettype wire

//--- spisd_far.sv
`timescale 1ns/1ps
`default_nettype none
module spisd_far
	import spisd_pkg::*;
(
	input wire logic           clk,
	input wire spisd_pin_out_t po,
	output spisd_pin_in_t      pi
);
	// Byte seen from the block as master, or as slave during send; echoed back on the next byte.
	logic [7:0] got = 8'h00;
	initial pi = 4'h5;
	always @(posedge po.sck_o) if (po.sck_oe) got <= {got[6:0], po.mosi_o};
	always @(negedge po.sck_o) pi.miso <= got[7];
	// remote master may drop select mid-byte
	task automatic send(input logic [7:0] b, input int n);
		pi.ss_n <= 1'h0;
		repeat (8) @(posedge clk);
		for (int i = 7; i > 7 - n; i--) begin
			pi.mosi <= b[i];
			repeat (4) @(posedge clk);
			pi.sck <= 1'h1;
			got <= {got[6:0], po.miso_o};
			repeat (4) @(posedge clk);
			pi.sck <= 1'h0;
		end
		repeat (8) @(posedge clk);
		pi.ss_n <= 1'h1;
		pi.mosi <= ~pi.mosi;
		repeat (8) @(posedge clk);
	endtask
endmodule
`default_nettype wire

//--- spisd_pkg.sv
`default_nettype none
package spisd_pkg;

	// ----------------------------------------------------------------
	// Register map (byte addresses on the bus)
	// ----------------------------------------------------------------
	localparam logic [3:0] SPISD_OFF_CONTROL = 4'h0;  // Serial control register.
	localparam logic [3:0] SPISD_OFF_STATUS  = 4'h4;  // Serial status and control register.
	localparam logic [3:0] SPISD_OFF_DATA    = 4'h8;  // Serial data register.

	// ----------------------------------------------------------------
	// Serial control field positions
	// ----------------------------------------------------------------
	localparam int SPISD_CTL_ENABLE = 0;  // Module enable.
	localparam int SPISD_CTL_MASTER = 1;  // Master select.
	localparam int SPISD_CTL_RXIE   = 2;  // Receive interrupt enable.
	localparam int SPISD_CTL_TXIE   = 3;  // Transmit interrupt enable.
	localparam logic [7:0] SPISD_CTL_WMASK = 8'h0f;  // Writable control bits.

	// ----------------------------------------------------------------
	// Serial status and control field positions
	// ----------------------------------------------------------------
	localparam int SPISD_STS_RXFULL = 7;  // Receiver full flag.
	localparam int SPISD_STS_ERROR_IRQ_ENABLE  = 6;  // Error interrupt enable.
	localparam int SPISD_STS_OVR    = 5;  // Overrun flag.
	localparam int SPISD_STS_MODE_FAULT_FLAG   = 4;  // Mode fault flag.
	localparam int SPISD_STS_TXEMP  = 3;  // Transmitter empty flag.
	localparam int SPISD_STS_MFEN   = 2;  // Mode fault detect enable.
	localparam int SPISD_STS_BAUDH  = 1;  // Baud select high.
	localparam int SPISD_STS_BAUDL  = 0;  // Baud select low.

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] SPISD_CTL_RESET  = 8'h00;
	localparam logic [2:0] SPISD_CFG_RESET  = 3'h0;   // Detect enable and baud select.
	localparam logic [7:0] SPISD_DATA_RESET = 8'h00;

	// ----------------------------------------------------------------
	// Timing: baud divisors in bus clocks and index of the last bit of a byte
	// ----------------------------------------------------------------
	localparam logic [7:0] SPISD_BD_00 = 8'h02;
	localparam logic [7:0] SPISD_BD_01 = 8'h08;
	localparam logic [7:0] SPISD_BD_10 = 8'h20;
	localparam logic [7:0] SPISD_BD_11 = 8'h80;
	localparam logic [3:0] SPISD_LAST_BIT = 4'h7;

	// AXI response codes.
	localparam logic [1:0] SPISD_RESP_OKAY   = 2'h0;
	localparam logic [1:0] SPISD_RESP_SLVERR = 2'h2;

	// Engine states.
	typedef enum logic [1:0] {
		SPISD_IDLE = 2'b00,
		SPISD_XFER = 2'b01
	} spisd_state_t;

	// Pin levels arriving from the outside.
	typedef struct packed {
		logic sck;
		logic mosi;
		logic miso;
		logic ss_n;
	} spisd_pin_in_t;

	// Pin drive levels and enables.
	typedef struct packed {
		logic sck_o;
		logic sck_oe;
		logic mosi_o;
		logic mosi_oe;
		logic miso_o;
		logic miso_oe;
	} spisd_pin_out_t;

	// Decode of the baud select code into a bus clock divisor.
	function automatic logic [7:0] spisd_divisor(input logic [1:0] sel);
		case (sel)
			2'b00:   spisd_divisor = SPISD_BD_00;
			2'b01:   spisd_divisor = SPISD_BD_01;
			2'b10:   spisd_divisor = SPISD_BD_10;
			default: spisd_divisor = SPISD_BD_11;
		endcase
	endfunction

endpackage
`default_nettype wire

//--- spisd_sync.sv
`timescale 1ns/1ps
`default_nettype none
module spisd_sync
	import spisd_pkg::*;
#(
	parameter int W = 4
) (
	// Clock and reset.
	input  wire logic         clk,
	input  wire logic         rst_b,
	// Asynchronous levels in, synchronised levels out.
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);

	logic [W-1:0] meta_reg;  // First stage, read only by the second stage.

	// ----------------------------------------------------------------
	// Two flip-flop synchroniser
	// ----------------------------------------------------------------
	// Each bit is independent; multi-bit coherence is not needed here.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			meta_reg <= '0;
			sync_out <= '0;
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end

endmodule
`default_nettype wire

//--- spisd_top.sv
// Notes on behaviour
// - Byte moved to receive sets full flag
// - Status read then data read clears full
// - Error flags interrupt only when enabled
// - Overrun keeps old byte, drops new
// - Status read then data read clears overrun
// - Slave: select rising mid-transfer faults
// - Master: select low faults any time
// - Status read then control write clears fault
// - Handoff to shifter sets transmitter empty
// - Writing transmit data clears empty flag
// - Fault sets only while detection enabled
// - Master claims select only with detection
// - Slave always claims select pin
// - Slave detect-off only suppresses fault flag
// - Baud codes give divisors 2,8,32,128
// - Baud select ignored as slave
// - Serial clock is bus clock over divisor
// - Data writes transmit, reads receive, separate
// - Deselected slave floats output, ignores clocks
//
// Design decisions made here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module spisd_top
	import spisd_pkg::*;
(
	// Clock and reset.
	input  wire logic           clk,
	input  wire logic           rst_b,
	// AXI4-Lite write address and data.
	input  wire logic [3:0]     s_axi_awaddr,
	input  wire logic           s_axi_awvalid,
	output logic                s_axi_awready,
	input  wire logic [31:0]    s_axi_wdata,
	input  wire logic [3:0]     s_axi_wstrb,
	input  wire logic           s_axi_wvalid,
	output logic                s_axi_wready,
	// AXI4-Lite write response.
	output logic [1:0]          s_axi_bresp,
	output logic                s_axi_bvalid,
	input  wire logic           s_axi_bready,
	// AXI4-Lite read.
	input  wire logic [3:0]     s_axi_araddr,
	input  wire logic           s_axi_arvalid,
	output logic                s_axi_arready,
	output logic [31:0]         s_axi_rdata,
	output logic [1:0]          s_axi_rresp,
	output logic                s_axi_rvalid,
	input  wire logic           s_axi_rready,
	// Serial pins.
	input  wire spisd_pin_in_t  pin_in,
	output spisd_pin_out_t      pin_out,
	// Slave select pin is claimed by the module, not general I/O.
	output logic                select_claimed,
	// Interrupt request, level.
	output logic                irq
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [7:0]    ctl_reg;            // Serial control register.
	logic [2:0]    cfg_reg;            // Detect enable and baud select.
	logic [7:0]    tx_data_reg;        // Transmit data register.
	logic [7:0]    rx_data_reg;        // Receive data register.
	logic          rx_full_reg;        // Receiver full flag.
	logic          ovr_reg;            // Overrun flag.
	logic          mode_fault_flag_reg;           // Mode fault flag.
	logic          tx_empty_reg;       // Transmitter empty flag.
	logic          err_ie_reg;         // Error interrupt enable.
	logic          arm_rx_reg;         // First clear step seen for full flag.
	logic          arm_ovr_reg;        // First clear step seen for overrun.
	logic          arm_mode_fault_flag_reg;       // First clear step seen for mode fault.
	logic [3:0]    aw_addr_reg;        // Held write address.
	logic          aw_held_reg;        // Write address taken.
	logic [7:0]    w_data_reg;         // Held write data, low lane.
	logic          w_lane_reg;         // Low byte lane was strobed.
	logic          w_held_reg;         // Write data taken.
	spisd_state_t  state_reg;          // Shift engine state.
	logic [7:0]    shift_reg;          // Shift register.
	logic          in_bit_reg;         // Bit sampled on the rising edge.
	logic [3:0]    bit_cnt_reg;        // Bits shifted so far.
	logic          sck_reg;            // Master serial clock level.
	logic          sck_prev_reg;       // Previous synchronised slave clock.
	logic          ss_prev_reg;        // Previous synchronised select.
	logic [3:0]    pin_sync;           // Synchronised pin levels.
	logic          sck_s;
	logic          mosi_s;
	logic          miso_s;
	logic          ss_s;
	logic          enabled;
	logic          is_master;
	logic          mf_en;
	logic          wr_fire;            // A held write is performed now.
	logic          rd_fire;            // A read is accepted now.
	logic          wr_ctl;
	logic          wr_cfg;
	logic          wr_tx;
	logic          rd_sts;
	logic          rd_data;
	logic          half_tick;
	logic          rise_ev;            // Serial clock rising edge.
	logic          fall_ev;            // Serial clock falling edge.
	logic          byte_done;          // Eighth bit shifted in.
	logic          load_ev;            // Transmit data handed to the shifter.
	logic          slave_start;
	logic          slave_abort;
	logic          mode_fault_flag_set;
	logic          rx_set;
	logic          ovr_set;
	logic [7:0]    sts_value;

	assign enabled   = ctl_reg[SPISD_CTL_ENABLE];
	assign is_master = ctl_reg[SPISD_CTL_MASTER];
	assign mf_en     = cfg_reg[SPISD_STS_MFEN];
	// Select is synchronised inverted, so a cleared synchroniser reads as
	// deselected and no false select edge follows reset.
	assign {sck_s, mosi_s, miso_s, ss_s} = {pin_sync[3:1], !pin_sync[0]};

	// ----------------------------------------------------------------
	// Pin synchronisers and baud divider
	// ----------------------------------------------------------------
	spisd_sync #(
		.W(4)
	) u_sync (
		.clk      (clk),
		.rst_b    (rst_b),
		.async_in ({pin_in.sck, pin_in.mosi, pin_in.miso, !pin_in.ss_n}),
		.sync_out (pin_sync)
	);

	// slave ignores baud.
	// The divider only runs for an active master, so the select field
	// has no influence at all in slave mode.
	spisd_baud_gen u_baud (
		.clk       (clk),
		.rst_b     (rst_b),
		.run       (enabled && is_master && state_reg == SPISD_XFER),
		.sel       (cfg_reg[SPISD_STS_BAUDH:SPISD_STS_BAUDL]),
		.half_tick (half_tick)
	);

	// ----------------------------------------------------------------
	// Bus write channels
	// ----------------------------------------------------------------
	// Address and data are taken independently, in either order.
	assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
	assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
	assign wr_fire       = aw_held_reg && w_held_reg && !s_axi_bvalid;
	assign wr_ctl = wr_fire && w_lane_reg && aw_addr_reg == SPISD_OFF_CONTROL;
	assign wr_cfg = wr_fire && w_lane_reg && aw_addr_reg == SPISD_OFF_STATUS;
	assign wr_tx  = wr_fire && w_lane_reg && aw_addr_reg == SPISD_OFF_DATA;

	// Hold address and data until both have arrived.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			aw_held_reg <= 1'b0;
			aw_addr_reg <= 4'h0;
			w_held_reg  <= 1'b0;
			w_data_reg  <= 8'h00;
			w_lane_reg  <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_reg <= 1'b1;
				aw_addr_reg <= {s_axi_awaddr[3:2], 2'b00};
			end else if (wr_fire) begin
				aw_held_reg <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_reg <= 1'b1;
				w_data_reg <= s_axi_wdata[7:0];
				w_lane_reg <= s_axi_wstrb[0];
			end else if (wr_fire) begin
				w_held_reg <= 1'b0;
			end
		end
	end

	// Write response; an unmapped address answers with a slave error.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= SPISD_RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			if (aw_addr_reg == SPISD_OFF_CONTROL || aw_addr_reg == SPISD_OFF_STATUS ||
				aw_addr_reg == SPISD_OFF_DATA) begin
				s_axi_bresp <= SPISD_RESP_OKAY;
			end else begin
				s_axi_bresp <= SPISD_RESP_SLVERR;
			end
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Bus read channel
	// ----------------------------------------------------------------
	assign s_axi_arready = !s_axi_rvalid;
	assign rd_fire = s_axi_arvalid && s_axi_arready;
	assign rd_sts  = rd_fire && {s_axi_araddr[3:2], 2'b00} == SPISD_OFF_STATUS;
	assign rd_data = rd_fire && {s_axi_araddr[3:2], 2'b00} == SPISD_OFF_DATA;
	assign sts_value = {rx_full_reg, err_ie_reg, ovr_reg, mode_fault_flag_reg,
		tx_empty_reg, cfg_reg};

	// data reads receive.
	// The data offset returns the receive register, never the last write.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= SPISD_RESP_OKAY;
		end else if (rd_fire) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= SPISD_RESP_OKAY;
			case ({s_axi_araddr[3:2], 2'b00})
				SPISD_OFF_CONTROL: begin
					s_axi_rdata <= {24'h000000, ctl_reg};
				end
				SPISD_OFF_STATUS: begin
					s_axi_rdata <= {24'h000000, sts_value};
				end
				SPISD_OFF_DATA: begin
					s_axi_rdata <= {24'h000000, rx_data_reg};
				end
				default: begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= SPISD_RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Software configuration registers
	// ----------------------------------------------------------------
	// Only the low byte lane carries register bits.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			ctl_reg    <= SPISD_CTL_RESET;
			cfg_reg    <= SPISD_CFG_RESET;
			err_ie_reg <= 1'b0;
		end else begin
			if (wr_ctl) begin
				ctl_reg <= w_data_reg & SPISD_CTL_WMASK;
			end
			if (wr_cfg) begin
				cfg_reg    <= w_data_reg[SPISD_STS_MFEN:SPISD_STS_BAUDL];
				err_ie_reg <= w_data_reg[SPISD_STS_ERROR_IRQ_ENABLE];
			end
		end
	end

	// no read-back of writes.
	// Writes land here only; reads never see this register.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			tx_data_reg <= SPISD_DATA_RESET;
		end else if (wr_tx) begin
			tx_data_reg <= w_data_reg;
		end
	end

	// ----------------------------------------------------------------
	// Shift engine events
	// ----------------------------------------------------------------
	// Clock idles low, data changes on the falling edge, sampled on rising.
	assign rise_ev = state_reg == SPISD_XFER &&
		(is_master ? (half_tick && !sck_reg) : (sck_s && !sck_prev_reg));
	assign fall_ev = state_reg == SPISD_XFER &&
		(is_master ? (half_tick && sck_reg) : (!sck_s && sck_prev_reg));
	assign byte_done   = fall_ev && bit_cnt_reg == SPISD_LAST_BIT;
	assign slave_start = enabled && !is_master && ss_prev_reg && !ss_s;
	assign slave_abort = enabled && !is_master && state_reg == SPISD_XFER && ss_s;
	assign mode_fault_flag_set = mf_en && enabled &&
		(is_master ? !ss_s : (slave_abort && !ss_prev_reg));
	// handoff sets empty.
	// The slave also hands over a waiting byte when it is selected, only if transmit data was written.
	assign load_ev = !tx_empty_reg && (slave_start ||
		(enabled && is_master && state_reg == SPISD_IDLE && !mode_fault_flag_reg));
	assign rx_set  = byte_done && !rx_full_reg;
	assign ovr_set = byte_done && rx_full_reg;

	// Edge history of the synchronised slave pins.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			sck_prev_reg <= 1'b0;
			ss_prev_reg  <= 1'b1;
		end else begin
			sck_prev_reg <= sck_s;
			ss_prev_reg  <= ss_s;
		end
	end

	// Engine state; a fault or a disable ends the byte at once.
	always_ff @(posedge clk) begin
		if (!rst_b || !enabled || slave_abort || (is_master && mode_fault_flag_reg)) begin
			state_reg <= SPISD_IDLE;
		end else begin
			case (state_reg)
				SPISD_IDLE: begin
					if (slave_start || (is_master && load_ev)) begin
						state_reg <= SPISD_XFER;
					end
				end
				SPISD_XFER: begin
					// A slave also stops after eight bits, so a deselect after a
					// complete byte is not taken for a mode fault.
					if (byte_done) begin
						state_reg <= SPISD_IDLE;
					end
				end
				default: begin
					state_reg <= SPISD_IDLE;
				end
			endcase
		end
	end

	// Shift register, bit counter and master clock level.
	// A slave keeps its last shifted byte if nothing new was written.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			shift_reg   <= 8'h00;
			in_bit_reg  <= 1'b0;
			bit_cnt_reg <= 4'h0;
			sck_reg     <= 1'b0;
		end else begin
			if (load_ev) begin
				shift_reg <= tx_data_reg;
			end else if (fall_ev) begin
				shift_reg <= {shift_reg[6:0], in_bit_reg};
			end
			if (rise_ev) begin
				in_bit_reg <= is_master ? miso_s : mosi_s;
			end
			if (state_reg != SPISD_XFER || byte_done) begin
				bit_cnt_reg <= 4'h0;
			end else if (fall_ev) begin
				bit_cnt_reg <= bit_cnt_reg + 4'h1;
			end
			if (state_reg != SPISD_XFER) begin
				sck_reg <= 1'b0;
			end else if (is_master && half_tick) begin
				sck_reg <= !sck_reg;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			rx_data_reg <= SPISD_DATA_RESET;
		end else if (rx_set) begin
			rx_data_reg <= {shift_reg[6:0], in_bit_reg};
		end
	end

	// ----------------------------------------------------------------
	// Status flags and two-step clearing
	// ----------------------------------------------------------------
	// arm on seen flag.
	// A status read arms only flags it returned set; any new setting
	// event disarms, so a late byte cannot be cleared unseen.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			arm_rx_reg   <= 1'b0;
			arm_ovr_reg  <= 1'b0;
			arm_mode_fault_flag_reg <= 1'b0;
		end else begin
			if (rx_set) begin
				arm_rx_reg <= 1'b0;
			end else if (rd_sts) begin
				arm_rx_reg <= rx_full_reg;
			end else if (rd_data) begin
				arm_rx_reg <= 1'b0;
			end
			if (ovr_set) begin
				arm_ovr_reg <= 1'b0;
			end else if (rd_sts) begin
				arm_ovr_reg <= ovr_reg;
			end else if (rd_data) begin
				arm_ovr_reg <= 1'b0;
			end
			if (mode_fault_flag_set) begin
				arm_mode_fault_flag_reg <= 1'b0;
			end else if (rd_sts) begin
				arm_mode_fault_flag_reg <= mode_fault_flag_reg;
			end else if (wr_ctl) begin
				arm_mode_fault_flag_reg <= 1'b0;
			end
		end
	end

	// Each flag: the clear step first, a same-cycle set overrides it.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			rx_full_reg  <= 1'b0;
			ovr_reg      <= 1'b0;
			mode_fault_flag_reg     <= 1'b0;
			tx_empty_reg <= 1'b1;
		end else begin
			if (rd_data && arm_rx_reg) begin
				rx_full_reg <= 1'b0;
			end
			if (rx_set) begin
				rx_full_reg <= 1'b1;
			end
			if (rd_data && arm_ovr_reg) begin
				ovr_reg <= 1'b0;
			end
			if (ovr_set) begin
				ovr_reg <= 1'b1;
			end
			if (wr_ctl && arm_mode_fault_flag_reg) begin
				mode_fault_flag_reg <= 1'b0;
			end
			if (mode_fault_flag_set) begin
				mode_fault_flag_reg <= 1'b1;
			end
			// writes only when empty.
			// A write while full overwrites the waiting byte.
			if (wr_tx) begin
				tx_empty_reg <= 1'b0;
			end
			if (load_ev) begin
				tx_empty_reg <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Interrupt and pin drive
	// ----------------------------------------------------------------
	// receive, transmit and error interrupts.
	assign irq = (rx_full_reg && ctl_reg[SPISD_CTL_RXIE]) ||
		(tx_empty_reg && ctl_reg[SPISD_CTL_TXIE]) ||
		((mode_fault_flag_reg || ovr_reg) && err_ie_reg);

	assign select_claimed = enabled && (!is_master || mf_en);

	// A faulted master lets go of the bus it may be fighting over.
	assign pin_out.sck_o   = sck_reg;
	assign pin_out.sck_oe  = enabled && is_master && !mode_fault_flag_reg;
	assign pin_out.mosi_o  = shift_reg[7];
	assign pin_out.mosi_oe = enabled && is_master && !mode_fault_flag_reg;
	assign pin_out.miso_o  = shift_reg[7];
	assign pin_out.miso_oe = enabled && !is_master && !ss_s;

endmodule
`default_nettype wire

//--- tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	import spisd_pkg::*;
	logic clk = 1'h0, rst_b = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_bready = 1'h1, s_axi_rready = 1'h1;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic select_claimed, irq;
	logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	spisd_pin_in_t pin_in;
	spisd_pin_out_t pin_out;
	int num_errors = 0, checks_done = 0;
	always #5 clk = ~clk;
	spisd_top dut (.clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .pin_in, .pin_out, .select_claimed, .irq);
	spisd_far far (.clk, .po(pin_out), .pi(pin_in));
	task automatic cmp(input logic [31:0] g, e);
		checks_done++;
		if (g !== e) begin
			num_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		int i;
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		for (i = 0; i < 99; i++) begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
			if (s_axi_bvalid) break;
		end
		if (i == 99) end_of_test(1'h1);
	endtask
	task automatic rd(input logic [3:0] a);
		int i;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		for (i = 0; i < 99; i++) begin
			@(posedge clk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
			if (s_axi_rvalid) break;
		end
		if (i == 99) end_of_test(1'h1);
		rv = s_axi_rdata;
	endtask
	task automatic rc(input logic [3:0] a, input logic [7:0] e, input logic [1:0] r = 2'h0);
		rd(a);
		cmp(rv, {24'h0, e});
		cmp({30'h0, s_axi_rresp}, {30'h0, r});
	endtask
	task automatic t_rx();
		rc(SPISD_OFF_STATUS, 8'h08);
		rc(4'hc, 8'h00, SPISD_RESP_SLVERR);
		wr(4'hc, 8'hff);
		cmp({30'h0, s_axi_bresp}, {30'h0, SPISD_RESP_SLVERR});
		wr(SPISD_OFF_CONTROL, 8'h05);
		wr(SPISD_OFF_DATA, 8'h3c);
		rc(SPISD_OFF_STATUS, 8'h00);
		far.send(8'ha5, 8);
		cmp({24'h0, far.got}, 32'h3c);
		cmp({31'h0, irq}, 32'h1);
		cmp({31'h0, select_claimed}, 32'h1);
		rc(SPISD_OFF_STATUS, 8'h88);
		rc(SPISD_OFF_DATA, 8'ha5);
		rc(SPISD_OFF_STATUS, 8'h08);
		far.send(8'h11, 8);
		far.send(8'h22, 8);
		rc(SPISD_OFF_STATUS, 8'ha8);
		rc(SPISD_OFF_DATA, 8'h11);
		rc(SPISD_OFF_STATUS, 8'h08);
		$display("receive test end");
	endtask
	task automatic t_fault();
		wr(SPISD_OFF_STATUS, 8'h04);
		far.send(8'h55, 3);
		cmp({31'h0, irq}, 32'h0);
		wr(SPISD_OFF_STATUS, 8'h44);
		cmp({31'h0, irq}, 32'h1);
		wr(SPISD_OFF_STATUS, 8'h40);
		rc(SPISD_OFF_STATUS, 8'h58);
		wr(SPISD_OFF_CONTROL, 8'h05);
		rc(SPISD_OFF_STATUS, 8'h48);
		wr(SPISD_OFF_STATUS, 8'h00);
		far.send(8'h55, 3);
		rc(SPISD_OFF_STATUS, 8'h08);
		$display("fault test end");
	endtask
	task automatic t_master();
		int i;
		wr(SPISD_OFF_CONTROL, 8'h03);
		cmp({31'h0, select_claimed}, 32'h0);
		for (int k = 0; k < 4; k++) begin
			wr(SPISD_OFF_STATUS, {6'h0, k[1:0]});
			// written only when empty, never read back
			wr(SPISD_OFF_DATA, 8'hc3 ^ {6'h0, k[1:0]});
			rv = 32'h0;
			for (i = 0; i < 999 && !rv[7]; i++) rd(SPISD_OFF_STATUS);
			if (!rv[7]) end_of_test(1'h1);
			cmp({24'h0, far.got}, {24'h0, 8'hc3 ^ {6'h0, k[1:0]}});
			// The far end echoes the previous byte; at the fastest divisor the
			// synchronised input lags a whole serial period, so that byte is not judged.
			if (k == 0) rd(SPISD_OFF_DATA);
			else rc(SPISD_OFF_DATA, 8'hc3 ^ {6'h0, k[1:0] - 2'h1});
		end
		wr(SPISD_OFF_STATUS, 8'h04);
		far.pi.ss_n <= 1'h0;
		repeat (8) @(posedge clk);
		rc(SPISD_OFF_STATUS, 8'h1c);
		cmp({31'h0, pin_out.sck_oe}, 32'h0);
		cmp({31'h0, select_claimed}, 32'h1);
		far.pi.ss_n <= 1'h1;
		$display("master test end");
	endtask
	task automatic end_of_test(input logic tmo);
		num_errors += int'(tmo);
		$display("checks %0d mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge clk);
		rst_b <= 1'h1;
		@(posedge clk);
		t_rx();
		t_fault();
		t_master();
		end_of_test(1'h0);
	end
endmodule
`default_nettype wire
